// ===== cpu_exception_entry.sv
// Exception, reset vector and debug halt entry logic of the CPU
// Summary of operation
// - Source events set flags; requests forward only when local enable is 1.
// - Unmasked request: finish instruction, push pcl, pch, ptr low, sum, ccr.
// - After stacking set global mask, fetch top-priority vector, run there.
// - Vector is two bytes: high byte at lower address, low byte next.
// - Reset end with mode select pin high and no forced debug reset: run from 0xfffe-0xffff vector.
// - Mode select low at power-on, or forced debug reset, enters debug halt.
// - Debug halt also on halt command, instruction, controller or module break while running.
// - In debug halt no application instructions run; only debug commands.
// - Wait halts the core while system clocks keep running.
// - Stop halts all clocks; light keeps power, deep keeps only RAM.
`timescale 1ns/1ps
module cpu_exception_entry
	import exc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic powerOnClear,
	input wire logic debugForceReset,
	input wire logic debugModeSelectPin,
	input wire logic [NUM_SRC-1:0] srcEvent,
	input wire logic [NUM_SRC-1:0] srcEnable,
	input wire logic [NUM_SRC-1:0] srcFlagClear,
	input wire logic instrBoundary,
	input wire context_t cpuContext,
	input wire logic debugHaltCmd,
	input wire logic enterDebugInstr,
	input wire logic debugCtrlBreak,
	input wire logic breakModuleMatch,
	input wire logic debugGoCmd,
	input wire logic waitInstr,
	input wire logic stopInstr,
	input wire logic deepStopSel,
	input wire logic [7:0] memRdData,
	output membus_t memBus,
	output logic [NUM_SRC-1:0] srcFlags,
	output logic irqPending,
	output logic coreRun,
	output logic debugHalted,
	output logic sysClockEn,
	output logic [1:0] haltKind,
	output logic [15:0] pcLoad,
	output logic pcLoadStb,
	output logic maskSet,
	output logic [15:0] stackPtr
);
	exc_state_t s_r;
	exc_state_t s_nxt;
	logic [NUM_SRC-1:0] req;
	logic takeIrq;
	logic debugTrig;
	logic bootDebug_r;

	// Highest index wins priority
	function automatic logic [2:0] topSrc(input logic [NUM_SRC-1:0] r);
		logic [2:0] idx;
		idx = 3'h0;
		for (int i = 0; i < NUM_SRC; i++) begin
			if (r[i]) begin
				idx = 3'(i);
			end
		end
		return idx;
	endfunction

	// ****************************************
	// Request forwarding
	// ****************************************
	assign req = s_r.flags & srcEnable;
	assign takeIrq = |req && !cpuContext.condition_code_reg[CCR_MASK_BIT]
		&& instrBoundary;
	assign debugTrig = debugHaltCmd | enterDebugInstr | debugCtrlBreak
		| breakModuleMatch;

	// Mode select level caught after reset release
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bootDebug_r <= 1'b0;
		end else if (s_r.state == ST_RESET) begin
			bootDebug_r <= (powerOnClear && !debugModeSelectPin)
				|| debugForceReset;
		end
	end

	// ****************************************
	// Sequencer
	// ****************************************
	always_comb begin
		s_nxt = s_r;
		s_nxt.bus = '0;
		s_nxt.maskSet = 1'b0;
		s_nxt.loadStb = 1'b0;
		// Set wins over clear
		s_nxt.flags = (s_r.flags & ~srcFlagClear) | srcEvent;
		case (s_r.state)
			ST_RESET: begin
				s_nxt.sp = SP_RESET;
				s_nxt.state = ST_VECHI;
				s_nxt.vecAddr = RESET_VEC;
				s_nxt.bus.read = 1'b1;
				s_nxt.bus.addr = RESET_VEC;
			end
			ST_VECHI: begin
				s_nxt.vecHi = memRdData;
				s_nxt.bus.read = 1'b1;
				s_nxt.bus.addr = s_r.vecAddr + 16'h0001;
				s_nxt.state = ST_VECLO;
			end
			ST_VECLO: begin
				s_nxt.newPc = {s_r.vecHi, memRdData};
				s_nxt.loadStb = 1'b1;
				if (s_r.vecAddr == RESET_VEC && bootDebug_r) begin
					s_nxt.state = ST_DEBUG;
				end else begin
					s_nxt.state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (debugTrig) begin
					s_nxt.state = ST_DEBUG;
				end else if (takeIrq) begin
					s_nxt.state = ST_PUSH;
					s_nxt.pushIdx = 3'h0;
				end else if (waitInstr) begin
					s_nxt.state = ST_WAIT;
				end else if (stopInstr) begin
					s_nxt.state = ST_STOP;
					s_nxt.haltKind = deepStopSel ? HALT_DEEP : HALT_LIGHT;
				end
			end
			ST_PUSH: begin
				// Extra cycle keeps the vector read off the last push
				if (s_r.pushIdx == 3'h5) begin
					s_nxt.maskSet = 1'b1;
					s_nxt.vecAddr = VEC_BASE
						+ {12'h000, topSrc(req), 1'b0};
					s_nxt.bus.read = 1'b1;
					s_nxt.bus.addr = s_nxt.vecAddr;
					s_nxt.state = ST_VECHI;
				end else begin
					s_nxt.bus.write = 1'b1;
					s_nxt.bus.addr = s_r.sp;
					case (s_r.pushIdx)
						3'h0: s_nxt.bus.data = cpuContext.pc[7:0];
						3'h1: s_nxt.bus.data = cpuContext.pc[15:8];
						3'h2: s_nxt.bus.data = cpuContext.ptrLow;
						3'h3: s_nxt.bus.data = cpuContext.sum;
						default: s_nxt.bus.data = cpuContext.condition_code_reg;
					endcase
					s_nxt.sp = s_r.sp - 16'h0001;
					s_nxt.pushIdx = s_r.pushIdx + 3'h1;
				end
			end
			ST_DEBUG: begin
				if (debugGoCmd) begin
					s_nxt.state = ST_RUN;
				end
			end
			ST_WAIT: begin
				if (|req) begin
					s_nxt.state = ST_RUN;
				end
			end
			ST_STOP: begin
				if (|req) begin
					s_nxt.state = ST_RUN;
					s_nxt.haltKind = HALT_NONE;
				end
			end
			default: s_nxt.state = ST_RESET;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s_r <= '{state: ST_RESET, flags: '0, sp: SP_RESET,
				pushIdx: 3'h0, vecAddr: RESET_VEC, vecHi: 8'h00,
				newPc: 16'h0000, maskSet: 1'b0, haltKind: HALT_NONE,
				bus: '0, loadStb: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign memBus = s_r.bus;
	assign srcFlags = s_r.flags;
	assign irqPending = |req;
	assign coreRun = (s_r.state == ST_RUN);
	assign debugHalted = (s_r.state == ST_DEBUG);
	assign sysClockEn = (s_r.state != ST_STOP);
	assign haltKind = s_r.haltKind;
	assign pcLoad = s_r.newPc;
	assign pcLoadStb = s_r.loadStb;
	assign maskSet = s_r.maskSet;
	assign stackPtr = s_r.sp;

	// ****************************************
	// Checks
	// ****************************************
	sequence lastPush;
		s_r.state == ST_PUSH && s_r.pushIdx == 3'h5;
	endsequence
	a_push_decrement: assert property (@(posedge clk) disable iff (!rst_b)
		s_r.state == ST_PUSH && s_r.pushIdx != 3'h5
		|=> s_r.sp == $past(s_r.sp) - 16'h0001)
		else $error("stack pointer not decremented");
	a_flag_set: assert property (@(posedge clk) disable iff (!rst_b)
		|srcEvent |=> (s_r.flags & $past(srcEvent)) == $past(srcEvent))
		else $error("event flag lost");
	a_debug_entry: assert property (@(posedge clk) disable iff (!rst_b)
		s_r.state == ST_RUN && debugTrig |=> debugHalted)
		else $error("debug halt not entered");
	a_masked_irq: assert property (@(posedge clk) disable iff (!rst_b)
		s_r.state == ST_RUN && cpuContext.condition_code_reg[CCR_MASK_BIT] && !debugTrig
		&& !waitInstr && !stopInstr |=> s_r.state == ST_RUN)
		else $error("masked request taken");
	a_mask_after: assert property (@(posedge clk) disable iff (!rst_b)
		lastPush |=> maskSet)
		else $error("mask not set after stacking");
	a_debug_hold: assert property (@(posedge clk) disable iff (!rst_b)
		debugHalted && !debugGoCmd |=> debugHalted && !coreRun)
		else $error("debug halt left");
	a_stop_clock: assert property (@(posedge clk) disable iff (!rst_b)
		s_r.state == ST_STOP |-> !sysClockEn)
		else $error("clocks run in stop");
	a_wait_clock: assert property (@(posedge clk) disable iff (!rst_b)
		s_r.state == ST_WAIT |-> sysClockEn && !coreRun)
		else $error("wait state wrong");
endmodule

// ===== exc_pkg.sv
// Package for the exception and debug entry block
package exc_pkg;
	localparam logic [15:0] RESET_VEC = 16'hfffe;
	localparam int NUM_SRC = 8;
	localparam logic [15:0] VEC_BASE = 16'hffe0;
	localparam logic [15:0] SP_RESET = 16'h00ff;
	localparam int CCR_MASK_BIT = 3;
	localparam logic [1:0] HALT_NONE = 2'h0;
	localparam logic [1:0] HALT_LIGHT = 2'h1;
	localparam logic [1:0] HALT_DEEP = 2'h2;

	typedef enum logic [3:0] {
		ST_RESET, ST_VECHI, ST_VECLO, ST_RUN, ST_PUSH, ST_DEBUG,
		ST_WAIT, ST_STOP
	} state_t;

	typedef struct packed {
		logic [7:0] condition_code_reg;
		logic [7:0] sum;
		logic [7:0] ptrLow;
		logic [15:0] pc;
	} context_t;

	typedef struct packed {
		logic write;
		logic read;
		logic [15:0] addr;
		logic [7:0] data;
	} membus_t;

	typedef struct packed {
		state_t state;
		logic [NUM_SRC-1:0] flags;
		logic [15:0] sp;
		logic [2:0] pushIdx;
		logic [15:0] vecAddr;
		logic [7:0] vecHi;
		logic [15:0] newPc;
		logic maskSet;
		logic loadStb;
		logic [1:0] haltKind;
		membus_t bus;
	} exc_state_t;
endpackage

// ===== vec_mem.sv
// Memory model answering the block's vector reads
`timescale 1ns/1ps
module vec_mem
	import exc_pkg::*;
(
	input wire membus_t memBus,
	output logic [7:0] memRdData
);
	// ****************
	// Read answer
	// ****************
	// Data stands while the read is on the bus, else another pattern
	always_comb begin
		if (memBus.read) begin
			memRdData = memBus.addr[7:0] ^ 8'h5a;
		end else begin
			memRdData = memBus.addr[7:0] ^ 8'ha5;
		end
	end
endmodule

// ===== tb.sv
// Self-checking bench of the exception and debug entry block
`timescale 1ns/1ps
module tb
	import exc_pkg::*;
;
	logic clk, rst_b, powerOnClear, debugForceReset, debugModeSelectPin;
	logic [NUM_SRC-1:0] srcEvent, srcEnable, srcFlagClear, srcFlags;
	logic instrBoundary, deepStopSel, irqPending, coreRun, debugHalted;
	logic sysClockEn, pcLoadStb, maskSet, sawMask;
	logic [6:0] ev;
	logic [7:0] memRdData;
	logic [1:0] haltKind;
	logic [15:0] pcLoad, stackPtr;
	context_t cpuContext;
	membus_t memBus;
	int badCount, nTests, k;
	cpu_exception_entry cpu_exception_entry_i (.*, .debugHaltCmd(ev[0]),
		.enterDebugInstr(ev[1]), .debugCtrlBreak(ev[2]),
		.breakModuleMatch(ev[3]), .debugGoCmd(ev[4]),
		.waitInstr(ev[5]), .stopInstr(ev[6]));
	vec_mem vec_mem_i (.memBus(memBus), .memRdData(memRdData));
	// ****************
	// Helpers
	// ****************
	function automatic logic [15:0] vec(input logic [15:0] a);
		vec = {a[7:0] ^ 8'h5a, (a[7:0] + 8'h01) ^ 8'h5a};
	endfunction
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		if (rst_b !== 1'b1) begin
			sawMask <= 1'b0;
		end else if (maskSet === 1'b1) begin
			sawMask <= 1'b1;
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		nTests++;
		if (got !== exp) begin
			badCount++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop;
		$display("checks=%0d errors=%0d", nTests, badCount);
		if (badCount == 0 && nTests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic hold(input logic bus);
		for (int i = 0; i < 40; i++) begin
			@(negedge clk);
			if (bus && (memBus.read | memBus.write) === 1'b1) return;
			if (!bus && (coreRun | debugHalted) === 1'b1) return;
		end
		badCount++;
		report_and_stop;
	endtask
	task automatic op(input logic w, input logic [15:0] a,
		input logic [7:0] d);
		hold(1'b1);
		chk({15'h0, memBus.write}, {15'h0, w});
		chk(memBus.addr, a);
		if (w) chk({8'h00, memBus.data}, {8'h00, d});
	endtask
	task automatic pls(input int b);
		@(posedge clk);
		ev <= 7'h01 << b;
		@(posedge clk);
		ev <= 7'h00;
		@(negedge clk);
	endtask
	task automatic src(input logic [7:0] e, input logic [7:0] c);
		@(posedge clk);
		srcEvent <= e;
		srcFlagClear <= c;
		@(posedge clk);
		srcEvent <= 8'h00;
		srcFlagClear <= 8'h00;
	endtask
	task automatic rst(input logic ms, input logic po, input logic fr);
		@(posedge clk);
		rst_b <= 1'b0;
		debugModeSelectPin <= ms;
		powerOnClear <= po;
		debugForceReset <= fr;
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		op(1'b0, RESET_VEC, 8'h00);
		op(1'b0, RESET_VEC + 16'h0001, 8'h00);
		hold(1'b0);
		chk({15'h0, pcLoadStb}, 16'h0001);
	endtask
	// ****************
	// Main sequence
	// ****************
	initial begin
		{rst_b, powerOnClear, debugForceReset, debugModeSelectPin} = 4'h0;
		{srcEvent, srcEnable, srcFlagClear} = '0;
		{instrBoundary, deepStopSel} = 2'h0;
		ev = 7'h00;
		cpuContext = '{8'h08, 8'h33, 8'h44, 16'h1234};
		badCount = 0;
		nTests = 0;
		rst(1'b1, 1'b1, 1'b0);
		chk({15'h0, coreRun}, 16'h0001);
		chk(pcLoad, vec(RESET_VEC));
		@(posedge clk);
		srcEnable <= 8'h20;
		instrBoundary <= 1'b1;
		src(8'h21, 8'h00);
		@(negedge clk);
		chk({7'h0, irqPending, srcFlags}, 16'h0121);
		repeat (3) @(negedge clk);
		chk({15'h0, memBus.write}, 16'h0000);
		@(posedge clk);
		cpuContext.condition_code_reg <= 8'h00;
		op(1'b1, 16'h00ff, 8'h34);
		op(1'b1, 16'h00fe, 8'h12);
		op(1'b1, 16'h00fd, 8'h44);
		op(1'b1, 16'h00fc, 8'h33);
		op(1'b1, 16'h00fb, 8'h00);
		@(posedge clk);
		cpuContext.condition_code_reg <= 8'h08;
		op(1'b0, VEC_BASE + 16'h000a, 8'h00);
		op(1'b0, VEC_BASE + 16'h000b, 8'h00);
		hold(1'b0);
		chk(pcLoad, vec(VEC_BASE + 16'h000a));
		chk({15'h0, pcLoadStb}, 16'h0001);
		chk({15'h0, sawMask}, 16'h0001);
		chk(stackPtr, 16'h00fa);
		src(8'h00, 8'h20);
		@(negedge clk);
		chk({7'h0, irqPending, srcFlags}, 16'h0001);
		src(8'h00, 8'h01);
		for (k = 0; k < 4; k++) begin
			pls(k);
			chk({14'h0, debugHalted, coreRun}, 16'h0002);
			pls(4);
			chk({14'h0, debugHalted, coreRun}, 16'h0001);
		end
		pls(5);
		chk({14'h0, coreRun, sysClockEn}, 16'h0001);
		src(8'h20, 8'h00);
		hold(1'b0);
		src(8'h00, 8'h20);
		for (k = 0; k < 2; k++) begin
			@(posedge clk);
			deepStopSel <= k[0];
			pls(6);
			chk({13'h0, sysClockEn, haltKind},
				{14'h0, k[0] ? HALT_DEEP : HALT_LIGHT});
			src(8'h20, 8'h00);
			hold(1'b0);
			src(8'h00, 8'h20);
		end
		rst(1'b0, 1'b1, 1'b0);
		chk({14'h0, debugHalted, coreRun}, 16'h0002);
		rst(1'b1, 1'b0, 1'b1);
		chk({14'h0, debugHalted, coreRun}, 16'h0002);
		report_and_stop;
	end
endmodule
